/* File: clock_startup_pkg.sv */
// Constants and carriers for the clock source selection and start-up sequencer.
// Assumes a single 100 MHz mclk domain; fuse and oscillator ticks arrive synchronous.
package clock_startup_pkg;
   localparam logic [3:0] SRC_EXTERNAL = 4'h0;
   localparam logic [3:0] SRC_RC_8MHZ = 4'h2;
   localparam logic [3:0] SRC_LOWPOWER_128K = 4'h4;
   localparam logic [3:0] SRC_LOW_FREQ_XTAL = 4'h6;
   localparam int SRC_XTAL_BIT = 3;
   localparam logic [1:0] SUT_SHORT = 2'h0;
   localparam logic [1:0] SUT_4MS = 2'h1;
   localparam logic [1:0] SUT_64MS = 2'h2;
   localparam logic [1:0] SUT_RESERVED = 2'h3;
   localparam logic [3:0] SHIPPED_SOURCE = 4'h2;
   localparam logic [1:0] SHIPPED_STARTUP = 2'h2;
   localparam logic SHIPPED_DIV8 = 1'b0;
   localparam logic FUSE_PROGRAMMED = 1'b0;
   localparam logic [15:0] WAKE_CLOCKS = 16'h0006;
   localparam logic [15:0] RESET_CLOCKS = 16'h000E;
   localparam logic [15:0] LFX_SHORT_CLOCKS = 16'h0400;
   localparam logic [15:0] LFX_LONG_CLOCKS = 16'h8000;
   localparam logic [15:0] XT_RES_FAST_CLOCKS = 16'h0102;
   localparam logic [15:0] XT_RES_CLOCKS = 16'h0400;
   localparam logic [15:0] XT_CRYSTAL_CLOCKS = 16'h4000;
   localparam logic [13:0] WDOG_4MS_CYCLES = 14'h0200;
   localparam logic [13:0] WDOG_64MS_CYCLES = 14'h2000;
   localparam logic [13:0] WDOG_NONE = 14'h0000;
   localparam logic [7:0] TRIM_RESET = 8'h00;

   typedef enum logic [2:0] {
      SRC_EXT = 3'b000,
      SRC_RC = 3'b001,
      SRC_LP = 3'b010,
      SRC_LFX = 3'b011,
      SRC_XTAL = 3'b100,
      SRC_BAD = 3'b101
   } source_e;

   typedef struct packed {
      logic [3:0] clock_source_select_fuses;
      logic [1:0] startup_time_fuses;
      logic divide_by_eight_fuse;
      logic reset_pin_disable_fuse;
   } fuses_s;

   typedef struct packed {
      logic core_clock;
      logic peripheral_clock;
      logic flash_interface_clock;
      logic converter_clock;
   } clock_gates_s;
endpackage

/* File: system_clock_source_startup.sv */
// Clock source decode, start-up delay sequencing, trim register and domain gating.
// Assumes fuses stable after power-up, tick inputs are one-cycle pulses in mclk.
//
// Operation
// - Decode four-bit source field into external, RC, 128 kHz, low-freq crystal, crystal.
// - Fuse bit one means unprogrammed, zero means programmed.
// - Power-down wake waits selected-source cycles before releasing execution.
// - Reset adds 512 or 8192 watchdog-oscillator cycles for 4 or 64 ms options.
// - External clock: wake 6 clocks; reset 14, 14+4 ms, 14+64 ms; 11 reserved.
// - RC and 128 kHz use the same start-up encoding as external clock.
// - Reset pin disabled with internal oscillator code 00 stretches reset to 14+4 ms.
// - Every reset loads the factory calibration byte into the trim register.
// - Software may overwrite the trim register; the RC trim follows it.
// - Watchdog and reset time-out always count the watchdog oscillator.
// - Shipped defaults: source 0010, start-up 10, divide-by-eight programmed.
// - Sleep mode gates unused clocks; halted core clock stops core state.
// - Some external interrupts are detected asynchronously while peripheral clock stops.
// - Converter clock runs on its own while core and peripheral clocks halt.
// - Flash interface clock is gated in step with the core clock.
`timescale 1ns/1ps
module system_clock_source_startup
   import clock_startup_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire fuses_s fuses,
   input wire logic use_shipped_fuses,
   input wire logic source_tick,
   input wire logic watchdog_tick,
   input wire logic wake_request,
   input wire logic [7:0] factory_trim,
   input wire logic trim_write,
   input wire logic [7:0] trim_write_data,
   input wire logic sleep_core,
   input wire logic sleep_peripheral,
   input wire logic sleep_converter,
   input wire logic async_interrupt,
   output logic [2:0] selected_source,
   output logic source_reserved,
   output logic div8_active,
   output logic [7:0] rc_trim_register,
   output logic run,
   output logic internal_reset,
   output clock_gates_s gates,
   output logic wake_from_interrupt,
   output logic watchdog_clock_tick
);
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_SOURCE = 2'b01,
      ST_WDOG = 2'b10,
      ST_RUN = 2'b11
   } seq_e;

   fuses_s f;
   source_e src;
   logic internal_osc;
   logic [15:0] wake_target;
   logic [13:0] wdog_target;
   logic [15:0] src_count;
   logic [13:0] wdog_count;
   logic from_reset;
   seq_e state;
   logic reserved_code;
   logic [15:0] source_target;
   logic source_done;
   logic wdog_done;

   always_comb begin
      if (use_shipped_fuses) begin
         f = '{SHIPPED_SOURCE, SHIPPED_STARTUP, SHIPPED_DIV8, ~FUSE_PROGRAMMED};
      end else begin
         f = fuses;
      end
   end

   always_comb begin
      if (f.clock_source_select_fuses[SRC_XTAL_BIT]) begin
         src = SRC_XTAL;
      end else begin
         case (f.clock_source_select_fuses)
            SRC_EXTERNAL: src = SRC_EXT;
            SRC_RC_8MHZ: src = SRC_RC;
            SRC_LOWPOWER_128K: src = SRC_LP;
            SRC_LOW_FREQ_XTAL: src = SRC_LFX;
            default: src = SRC_BAD;
         endcase
      end
   end

   assign internal_osc = (src == SRC_RC) || (src == SRC_LP);

   // Delay table; the reset path counts the fixed 14 clocks in place of the wake count
   always_comb begin
      wake_target = WAKE_CLOCKS;
      wdog_target = WDOG_NONE;
      case (src)
         SRC_EXT, SRC_RC, SRC_LP: begin
            wake_target = WAKE_CLOCKS;
            case (f.startup_time_fuses)
               SUT_4MS: wdog_target = WDOG_4MS_CYCLES;
               SUT_64MS: wdog_target = WDOG_64MS_CYCLES;
               default: wdog_target = WDOG_NONE;
            endcase
            if (internal_osc && f.startup_time_fuses == SUT_SHORT &&
                f.reset_pin_disable_fuse == FUSE_PROGRAMMED) begin
               wdog_target = WDOG_4MS_CYCLES;
            end
         end
         SRC_LFX: begin
            if (f.startup_time_fuses == SUT_64MS) begin
               wake_target = LFX_LONG_CLOCKS;
            end else begin
               wake_target = LFX_SHORT_CLOCKS;
            end
            if (f.startup_time_fuses == SUT_SHORT) begin
               wdog_target = WDOG_4MS_CYCLES;
            end else begin
               wdog_target = WDOG_64MS_CYCLES;
            end
         end
         SRC_XTAL: begin
            case ({f.clock_source_select_fuses[0], f.startup_time_fuses})
               3'h0: begin
                  wake_target = XT_RES_FAST_CLOCKS;
                  wdog_target = WDOG_4MS_CYCLES;
               end
               3'h1: begin
                  wake_target = XT_RES_FAST_CLOCKS;
                  wdog_target = WDOG_64MS_CYCLES;
               end
               3'h2: begin
                  wake_target = XT_RES_CLOCKS;
                  wdog_target = WDOG_NONE;
               end
               3'h3: begin
                  wake_target = XT_RES_CLOCKS;
                  wdog_target = WDOG_4MS_CYCLES;
               end
               3'h4: begin
                  wake_target = XT_RES_CLOCKS;
                  wdog_target = WDOG_64MS_CYCLES;
               end
               3'h5: begin
                  wake_target = XT_CRYSTAL_CLOCKS;
                  wdog_target = WDOG_NONE;
               end
               3'h6: begin
                  wake_target = XT_CRYSTAL_CLOCKS;
                  wdog_target = WDOG_4MS_CYCLES;
               end
               default: begin
                  wake_target = XT_CRYSTAL_CLOCKS;
                  wdog_target = WDOG_64MS_CYCLES;
               end
            endcase
         end
         default: begin
            wake_target = WAKE_CLOCKS;
            wdog_target = WDOG_NONE;
         end
      endcase
   end

   // Reserved codes decoded combinationally, so the first edge after
   // Reset already sees them; the registered status flag lags by one edge
   assign reserved_code = (src == SRC_BAD) ||
      (src != SRC_XTAL && f.startup_time_fuses == SUT_RESERVED);

   // Reset start-up counts the fixed 14 clocks, wake-up the table count
   assign source_target = from_reset ? RESET_CLOCKS : wake_target;
   assign source_done = (src_count >= source_target);
   assign wdog_done = (wdog_count >= wdog_target);

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= ST_RESET;
      end else begin
         case (state)
            ST_RESET: begin
               // Reserved codes never start, as no valid oscillator is known
               if (!reserved_code) begin
                  state <= ST_SOURCE;
               end
            end
            ST_SOURCE: begin
               if (source_done) begin
                  state <= from_reset ? ST_WDOG : ST_RUN;
               end
            end
            ST_WDOG: begin
               if (wdog_done) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               // Power-down wake re-times the selected source
               if (wake_request && sleep_core) begin
                  state <= ST_SOURCE;
               end
            end
            default: state <= ST_RESET;
         endcase
      end
   end

   // Selected-source cycle count; cleared outside its stage so a
   // Wake always starts from zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         src_count <= '0;
      end else if (state != ST_SOURCE) begin
         src_count <= '0;
      end else if (source_tick) begin
         src_count <= src_count + 16'h0001;
      end
   end

   // Real-time part on the watchdog oscillator, never the source
   always_ff @(posedge mclk) begin
      if (reset) begin
         wdog_count <= '0;
      end else if (state != ST_WDOG) begin
         wdog_count <= '0;
      end else if (watchdog_tick) begin
         wdog_count <= wdog_count + 14'h0001;
      end
   end

   // Set by reset, cleared once the reset-only watchdog stage completes
   always_ff @(posedge mclk) begin
      if (reset) begin
         from_reset <= 1'b1;
      end else if (state == ST_WDOG && wdog_done) begin
         from_reset <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rc_trim_register <= TRIM_RESET;
      // Factory load wins over a software write in the same cycle
      end else if (state == ST_RESET) begin
         rc_trim_register <= factory_trim;
      end else if (trim_write) begin
         rc_trim_register <= trim_write_data;
      end
   end

   // Decoded source, reported one edge later
   always_ff @(posedge mclk) begin
      if (reset) begin
         selected_source <= SRC_EXT;
      end else begin
         selected_source <= src;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         source_reserved <= 1'b0;
      end else begin
         source_reserved <= reserved_code;
      end
   end

   // Programmed (zero) divide fuse turns the divider on
   always_ff @(posedge mclk) begin
      if (reset) begin
         div8_active <= 1'b0;
      end else begin
         div8_active <= (f.divide_by_eight_fuse == FUSE_PROGRAMMED);
      end
   end

   assign run = (state == ST_RUN);
   // Reset stays asserted through both stages of a reset start-up;
   // A wake from power-down only holds off run
   assign internal_reset = (state == ST_RESET) || (from_reset && state != ST_RUN);
   // Watchdog always sees its own oscillator, whatever the source
   assign watchdog_clock_tick = watchdog_tick;
   // Asynchronous wake path bypasses the peripheral clock
   assign wake_from_interrupt = async_interrupt;

   // One gate per domain; the flash domain takes the core
   // Sleep request so both clocks stop in step
   localparam int DOMAIN_COUNT = $bits(clock_gates_s);
   logic [DOMAIN_COUNT-1:0] domain_sleep;
   logic [DOMAIN_COUNT-1:0] domain_gate;
   assign domain_sleep = {sleep_core, sleep_peripheral, sleep_core, sleep_converter};
   for (genvar d = 0; d < DOMAIN_COUNT; d++) begin : g_domain
      assign domain_gate[d] = run && !domain_sleep[d];
   end
   assign gates = domain_gate;
endmodule

/* File: system_clock_source_startup_checker.sv */
// Port-level checker for the clock source start-up sequencer.
// Assumes it is bound to the top module and the factory byte is held steady.
`timescale 1ns/1ps
module system_clock_source_startup_checker
   import clock_startup_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire clock_gates_s gates,
   input wire logic run,
   input wire logic internal_reset,
   input wire logic sleep_core,
   input wire logic sleep_converter,
   input wire logic wake_request,
   input wire logic watchdog_tick,
   input wire logic watchdog_clock_tick,
   input wire logic trim_write,
   input wire logic [7:0] trim_write_data,
   input wire logic [7:0] rc_trim_register,
   input wire logic [7:0] factory_trim,
   input wire logic source_reserved
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   property p_core; gates.core_clock == (run && !sleep_core); endproperty
   a_core: assert property (p_core) else $error("core clock gate wrong");
   property p_flash; gates.flash_interface_clock == gates.core_clock; endproperty
   a_flash: assert property (p_flash) else $error("flash clock not with core");
   property p_conv; gates.converter_clock == (run && !sleep_converter); endproperty
   a_conv: assert property (p_conv) else $error("converter clock gate wrong");
   property p_wdog; watchdog_clock_tick == watchdog_tick; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog tick not passed on");
   property p_load; $fell(reset) |-> ##[1:2] rc_trim_register == factory_trim; endproperty
   a_load: assert property (p_load) else $error("trim not loaded at reset");
   property p_write; run && trim_write |=> rc_trim_register == $past(trim_write_data); endproperty
   a_write: assert property (p_write) else $error("trim write lost");
   property p_resv; source_reserved |-> internal_reset && !run; endproperty
   a_resv: assert property (p_resv) else $error("reserved code left reset");
   property p_wake; run && sleep_core && wake_request |=> !run; endproperty
   a_wake: assert property (p_wake) else $error("wake did not restart delay");
   c_run: cover property ($rose(run));
   c_wake: cover property (run && sleep_core && wake_request);
   c_resv: cover property (source_reserved);
endmodule
bind system_clock_source_startup system_clock_source_startup_checker chk_i (.mclk, .reset,
   .gates, .run, .internal_reset, .sleep_core, .sleep_converter, .wake_request, .watchdog_tick,
   .watchdog_clock_tick, .trim_write, .trim_write_data, .rc_trim_register, .factory_trim,
   .source_reserved);

/* File: osc_model.sv */
// Oscillator model: selected source and watchdog oscillator as tick pulses.
// Assumes the single mclk domain; source ticks every cycle, watchdog every WD_DIV.
`timescale 1ns/1ps
module osc_model #(parameter int WD_DIV = 2) (
   input wire logic mclk,
   output logic source_tick = 1'b0,
   output logic watchdog_tick = 1'b0
);
   int ph = 0;
   always @(posedge mclk) source_tick <= 1'b1;
   always @(posedge mclk) begin
      ph <= (ph + 1) % WD_DIV;
      watchdog_tick <= (ph == 0);
   end
endmodule

/* File: system_clock_source_startup_tb_top.sv */
// Self-checking bench for the clock source start-up sequencer.
// Assumes osc_model supplies ticks; the bench drives fuses and controls.
`timescale 1ns/1ps
module system_clock_source_startup_tb_top import clock_startup_pkg::*;;
   typedef struct {logic [3:0] s; logic [1:0] t; logic rd; logic [2:0] es; logic er; int n;} row_s;
   row_s rows [11] = '{'{4'h0, 2'h0, 1, 3'h0, 0, 0}, '{4'h0, 2'h1, 1, 3'h0, 0, 512},
      '{4'h0, 2'h2, 1, 3'h0, 0, 8192}, '{4'h2, 2'h0, 1, 3'h1, 0, 0}, '{4'h2, 2'h0, 0, 3'h1, 0, 512},
      '{4'h4, 2'h1, 1, 3'h2, 0, 512}, '{4'h4, 2'h0, 0, 3'h2, 0, 512}, '{4'h6, 2'h0, 1, 3'h3, 0, 512},
      '{4'h9, 2'h1, 1, 3'h4, 0, 0}, '{4'h0, 2'h3, 1, 3'h0, 1, 30}, '{4'h1, 2'h0, 1, 3'h5, 1, 30}};
   logic mclk = 1'b0, reset = 1'b1, shipped = 1'b0, wake = 1'b0, twr = 1'b0;
   logic sc = 1'b0, sp = 1'b0, sv = 1'b0, irq = 1'b0, resv, div8, runo, ireset, wfi, wdo, st, wt;
   logic [7:0] twd = 8'h00, trim;
   logic [2:0] sel;
   fuses_s fz = 8'hFF;
   clock_gates_s g;
   int n_fail = 0, n_checks = 0, k, c, nw;
   always #5 mclk = ~mclk;
   osc_model model (.mclk(mclk), .source_tick(st), .watchdog_tick(wt));
   system_clock_source_startup dut (.mclk(mclk), .reset(reset), .fuses(fz),
      .use_shipped_fuses(shipped), .source_tick(st), .watchdog_tick(wt), .wake_request(wake),
      .factory_trim(8'h3C), .trim_write(twr), .trim_write_data(twd), .sleep_core(sc),
      .sleep_peripheral(sp), .sleep_converter(sv), .async_interrupt(irq), .selected_source(sel),
      .source_reserved(resv), .div8_active(div8), .rc_trim_register(trim), .run(runo),
      .internal_reset(ireset), .gates(g), .wake_from_interrupt(wfi), .watchdog_clock_tick(wdo));
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Reset with given fuses, count watchdog ticks seen until run rises
   task start(input fuses_s f, input logic shp, input logic hold);
      fz <= f;
      shipped <= shp;
      reset <= 1'b1;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      nw = 0;
      for (c = 0; c < (hold ? 60 : 16500) && runo !== 1'b1; c++) begin
         @(posedge mclk);
         nw += (wt === 1'b1 && ireset === 1'b1);
      end
      if (runo !== 1'b1 && !hold) begin
         n_fail++;
         finish_test();
      end
   endtask
   initial begin
      for (k = 0; k < 11; k++) begin
         start(fuses_s'{rows[k].s, rows[k].t, k[0], rows[k].rd}, 1'b0, rows[k].er);
         chk("source", sel, rows[k].es);
         chk("div8", div8, !k[0]);
         chk("held", ireset, rows[k].er);
         chk("wdog", nw >= rows[k].n && nw <= rows[k].n + 12, 1);
         $display("row %0d done", k);
      end
      start(fuses_s'{4'h0, 2'h0, 1'b1, 1'b1}, 1'b0, 1'b0);
      chk("trim load", trim, 8'h3C);
      sc <= 1'b1;
      sp <= 1'b1;
      irq <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("core", g.core_clock, 0);
      chk("peri", g.peripheral_clock, 0);
      chk("flash", g.flash_interface_clock, 0);
      chk("conv", g.converter_clock, 1);
      chk("async", wfi, 1);
      chk("wdog tick", wdo, wt);
      wake <= 1'b1;
      @(posedge mclk);
      wake <= 1'b0;
      sc <= 1'b0;
      sp <= 1'b0;
      // Let the wake edge land before polling run
      @(posedge mclk);
      for (c = 0; c < 20 && runo !== 1'b1; c++) @(posedge mclk);
      chk("wake", c >= 6 && c <= 10, 1);
      $display("wake test done");
      twd <= 8'hA5;
      twr <= 1'b1;
      @(posedge mclk);
      twr <= 1'b0;
      @(posedge mclk);
      chk("trim write", trim, 8'hA5);
      start(8'hFF, 1'b1, 1'b0);
      chk("shipped src", sel, 3'h1);
      chk("shipped div8", div8, 1);
      chk("shipped wdog", nw >= 8192 && nw <= 8204, 1);
      chk("trim reload", trim, 8'h3C);
      $display("shipped test done");
      finish_test();
   end
endmodule
